//--- design/spi_host_pkg.sv
/*
 * constants and types shared by the serial host controller:
 * register map of the controller, command bit layout, timing counts.
 * assumes a 40 MHz system clock and a device answering on a 4- or 3-wire link.
 */
package spi_host_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int IDLE_GAP_NS = 2000;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_GAP_CYC = (IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HALF_CNT = 4'(SCK_HALF_CYC - 1);
    localparam logic [6:0] IDLE_CNT = 7'(IDLE_GAP_CYC);

    // ------------------------------------------------------------
    // controller register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_ADDR = 6'h04;
    localparam logic [5:0] OFS_COUNT = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_DATA = 6'h20;

    // ctrl bits
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_3WIRE = 2;
    localparam int CTRL_MODE11 = 3;
    localparam int CTRL_WAKE = 4;
    // status bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_SEL = 2;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int BUF_DEPTH = 8;
    localparam logic [3:0] MAX_BYTES = 4'h8;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    // register address of the identity register in the device, neutral default
    localparam logic [6:0] ID_REG_ADDR = 7'h00;
    localparam logic [7:0] DUMMY_TX = 8'h00;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_START = 6'h02,
        S_LOW = 6'h04,
        S_HIGH = 6'h08,
        S_TAIL = 6'h10,
        S_END = 6'h20
    } state_t;

endpackage

//--- design/sck_tick.sv
/*
 * half-period tick generator for the serial clock.
 * assumes run is held high for the whole of a frame; counter restarts when run is low.
 */
`timescale 1ns/1ps
`default_nettype none

module sck_tick (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_tick
);

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t r, nxt;

    always_comb begin
        nxt = r;
        nxt.tick = 1'b0;
        if (!i_run) begin
            nxt.cnt = 4'h0;
        end else if (r.cnt == spi_host_pkg::HALF_CNT) begin
            nxt.cnt = 4'h0;
            nxt.tick = 1'b1;
        end else begin
            nxt.cnt = r.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign o_tick = r.tick;

endmodule

`default_nettype wire

//--- design/spi_host.sv
/*
 * host controller driving an accelerometer over its serial link.
 * software writes config, address, byte count and data over avalon-mm,
 * then starts a frame; read results land in the same data buffer.
 * assumes the device samples on rising sck and drives on falling sck.
 */
// Implementation choices: the address map and the Avalon-MM register port.
// Contract
// - host wake read of identity, discard result
// - 16-bit single frame, bursts supported
// - host drives select and serial clock
// - drive on falling edge, sample rising
// - single read: dummy byte then value
// - burst read n+1 bytes, drop first
// - first bit: zero write, one read
// - seven address bits then eight data bits
// - three-wire: clock high at select edges
// - two microseconds idle between accesses
`timescale 1ns/1ps
`default_nettype none

module spi_host (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [5:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_chip_select_n,
    output logic o_sck,
    output logic o_serial_in_pin_out,
    output logic o_serial_in_pin_oe,
    input wire logic i_serial_in_pin,
    input wire logic i_serial_out_pin
);

    typedef struct packed {
        spi_host_pkg::state_t st;
        logic cs_n;
        logic sck;
        logic sdx_out;
        logic sdx_oe;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [6:0] bitcnt;
        logic [6:0] total;
        logic [6:0] gap;
        logic rd;
        logic tw;
        logic cpol;
        logic disc;
        logic pend;
        logic [6:0] addr;
        logic [3:0] nbytes;
        logic [spi_host_pkg::BUF_DEPTH-1:0][7:0] buffer;
        logic done;
        logic sel;
        logic waitr;
        logic [31:0] rdata;
        logic sdo_s1;
        logic sdo_s2;
        logic sdx_s1;
        logic sdx_s2;
    } host_state_t;

    host_state_t r, nxt;
    logic tick;
    logic run;
    logic din;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] eff_bytes(input logic [3:0] n);
        if (n == 4'h0) begin
            eff_bytes = 4'h1;
        end else if (n > spi_host_pkg::MAX_BYTES) begin
            eff_bytes = spi_host_pkg::MAX_BYTES;
        end else begin
            eff_bytes = n;
        end
    endfunction

    function automatic logic [3:0] byte_of(input logic [6:0] bits);
        byte_of = bits[6:3];
    endfunction

    assign run = (r.st == spi_host_pkg::S_START) || (r.st == spi_host_pkg::S_LOW) ||
        (r.st == spi_host_pkg::S_HIGH) || (r.st == spi_host_pkg::S_TAIL);
    assign din = r.tw ? r.sdx_s2 : r.sdo_s2;

    sck_tick u_tick (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_run(run),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] nb;
        logic [3:0] idx;
        logic [7:0] rxn;
        nb = 7'h00;
        idx = 4'h0;
        rxn = 8'h00;
        nxt = r;
        // pin inputs pass two flops before use
        nxt.sdo_s1 = i_serial_out_pin;
        nxt.sdo_s2 = r.sdo_s1;
        nxt.sdx_s1 = i_serial_in_pin;
        nxt.sdx_s2 = r.sdx_s1;
        if (r.gap != spi_host_pkg::IDLE_CNT) begin
            nxt.gap = r.gap + 7'h01;
        end

        // avalon slave: one wait cycle, write takes effect when wait is low
        if (r.waitr && (i_read || i_write)) begin
            nxt.waitr = 1'b0;
            nxt.rdata = 32'h0000_0000;
            if (i_read) begin
                if (i_address == spi_host_pkg::OFS_CTRL) begin
                    nxt.rdata[spi_host_pkg::CTRL_READ] = r.rd;
                    nxt.rdata[spi_host_pkg::CTRL_3WIRE] = r.tw;
                    nxt.rdata[spi_host_pkg::CTRL_MODE11] = r.cpol;
                end else if (i_address == spi_host_pkg::OFS_ADDR) begin
                    nxt.rdata[6:0] = r.addr;
                end else if (i_address == spi_host_pkg::OFS_COUNT) begin
                    nxt.rdata[3:0] = r.nbytes;
                end else if (i_address == spi_host_pkg::OFS_STATUS) begin
                    nxt.rdata[spi_host_pkg::STAT_BUSY] = r.pend || run ||
                        (r.st == spi_host_pkg::S_END);
                    nxt.rdata[spi_host_pkg::STAT_DONE] = r.done;
                    nxt.rdata[spi_host_pkg::STAT_SEL] = r.sel;
                end else if (i_address[5] && (i_address[1:0] == 2'b00)) begin
                    nxt.rdata[7:0] = r.buffer[i_address[4:2]];
                end
            end
        end else if (!r.waitr) begin
            nxt.waitr = 1'b1;
            if (i_write && i_byteenable[0]) begin
                if (i_address == spi_host_pkg::OFS_CTRL) begin
                    if (!r.pend && (r.st == spi_host_pkg::S_IDLE)) begin
                        nxt.tw = i_writedata[spi_host_pkg::CTRL_3WIRE];
                        // three-wire frames run in mode 11 so sck is high at select edges
                        nxt.cpol = i_writedata[spi_host_pkg::CTRL_MODE11] ||
                            i_writedata[spi_host_pkg::CTRL_3WIRE];
                        // idle clock level settles a cycle before select falls
                        nxt.sck = nxt.cpol;
                        nxt.rd = i_writedata[spi_host_pkg::CTRL_READ];
                        nxt.disc = 1'b0;
                        nxt.pend = i_writedata[spi_host_pkg::CTRL_START];
                        if (i_writedata[spi_host_pkg::CTRL_WAKE]) begin
                            // single read of identity, result thrown away
                            nxt.rd = 1'b1;
                            nxt.disc = 1'b1;
                            nxt.pend = 1'b1;
                        end
                    end
                end else if (i_address == spi_host_pkg::OFS_ADDR) begin
                    nxt.addr = i_writedata[6:0];
                end else if (i_address == spi_host_pkg::OFS_COUNT) begin
                    nxt.nbytes = i_writedata[3:0];
                end else if (i_address == spi_host_pkg::OFS_STATUS) begin
                    if (i_writedata[spi_host_pkg::STAT_DONE]) begin
                        nxt.done = 1'b0;
                    end
                end else if (i_address[5] && (i_address[1:0] == 2'b00)) begin
                    nxt.buffer[i_address[4:2]] = i_writedata[7:0];
                end
            end
        end

        // serial frame engine
        case (r.st)
            spi_host_pkg::S_IDLE: begin
                // host opens each frame, after the idle gap has elapsed
                if (r.pend && (r.gap == spi_host_pkg::IDLE_CNT)) begin
                    nxt.pend = 1'b0;
                    nxt.st = spi_host_pkg::S_START;
                    nxt.cs_n = 1'b0;
                    nxt.sck = r.cpol;
                    nxt.sdx_oe = 1'b1;
                    nxt.bitcnt = 7'h00;
                    // direction bit leads, then address msb first
                    nxt.sdx_out = r.rd;
                    nxt.tx = {r.disc ? spi_host_pkg::ID_REG_ADDR : r.addr, 1'b0};
                    nb = {3'b000, r.disc ? 4'h1 : eff_bytes(r.nbytes)};
                    // reads carry one dummy byte ahead of the data
                    nxt.total = (nb + 7'(r.rd ? 2 : 1)) << 3;
                end
            end
            spi_host_pkg::S_START: begin
                if (tick) begin
                    nxt.sck = 1'b0;
                    nxt.st = spi_host_pkg::S_LOW;
                end
            end
            spi_host_pkg::S_LOW: begin
                if (tick) begin
                    // rising edge: sample the incoming bit
                    nxt.sck = 1'b1;
                    rxn = {r.rx[6:0], din};
                    nxt.rx = rxn;
                    nxt.bitcnt = r.bitcnt + 7'h01;
                    nxt.st = spi_host_pkg::S_HIGH;
                    idx = byte_of(nxt.bitcnt);
                    // first returned byte is the dummy and is dropped
                    if (r.rd && !r.disc && (nxt.bitcnt[2:0] == 3'b000) && (idx >= 4'h3)) begin
                        nxt.buffer[3'(idx - 4'h3)] = rxn;
                    end
                end
            end
            spi_host_pkg::S_HIGH: begin
                if (tick) begin
                    if (r.bitcnt == r.total) begin
                        if (r.cpol) begin
                            nxt.st = spi_host_pkg::S_END;
                        end else begin
                            nxt.sck = 1'b0;
                            nxt.st = spi_host_pkg::S_TAIL;
                        end
                    end else begin
                        // falling edge: change the outgoing bit
                        nxt.sck = 1'b0;
                        nxt.st = spi_host_pkg::S_LOW;
                        if (r.bitcnt[2:0] == 3'b000) begin
                            idx = byte_of(r.bitcnt);
                            if (r.rd) begin
                                nxt.tx = spi_host_pkg::DUMMY_TX;
                                // three-wire: release the shared pin for the device
                                nxt.sdx_oe = !r.tw;
                            end else begin
                                // burst write data follows the single address byte
                                nxt.tx = r.buffer[3'(idx - 4'h1)];
                            end
                            nxt.sdx_out = nxt.tx[7];
                            nxt.tx = {nxt.tx[6:0], 1'b0};
                        end else begin
                            nxt.sdx_out = r.tx[7];
                            nxt.tx = {r.tx[6:0], 1'b0};
                        end
                    end
                end
            end
            spi_host_pkg::S_TAIL: begin
                if (tick) begin
                    nxt.st = spi_host_pkg::S_END;
                end
            end
            spi_host_pkg::S_END: begin
                // closing rise of select also moves the device into spi
                nxt.cs_n = 1'b1;
                nxt.sdx_oe = !r.tw;
                nxt.sdx_out = 1'b0;
                nxt.done = 1'b1;
                nxt.sel = 1'b1;
                nxt.gap = 7'h00;
                nxt.st = spi_host_pkg::S_IDLE;
            end
            default: begin
                nxt.st = spi_host_pkg::S_IDLE;
                nxt.cs_n = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            // select held high after reset so the device keeps its default
            r <= '0;
            r.st <= spi_host_pkg::S_IDLE;
            r.cs_n <= 1'b1;
            r.sdx_oe <= 1'b1;
            r.waitr <= 1'b1;
            r.addr <= spi_host_pkg::ADDR_RESET;
            r.gap <= spi_host_pkg::IDLE_CNT;
        end else begin
            r <= nxt;
        end
    end

    assign o_readdata = r.rdata;
    assign o_waitrequest = r.waitr;
    assign o_chip_select_n = r.cs_n;
    assign o_sck = r.sck;
    assign o_serial_in_pin_out = r.sdx_out;
    assign o_serial_in_pin_oe = r.sdx_oe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_idle_cs;
        @(posedge i_mclk) disable iff (i_rst)
        (r.st == spi_host_pkg::S_IDLE) |-> o_chip_select_n;
    endproperty
    a_idle_cs: assert property (p_idle_cs) else $error("select low while idle");

    property p_mosi_edge;
        @(posedge i_mclk) disable iff (i_rst)
        (!o_chip_select_n && !$fell(o_chip_select_n) && $changed(o_serial_in_pin_out))
            |-> $fell(o_sck);
    endproperty
    a_mosi_edge: assert property (p_mosi_edge) else $error("data moved off falling edge");

    property p_sample_rise;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_sck) && !o_chip_select_n |-> r.bitcnt == $past(r.bitcnt) + 7'h01;
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("no sample on rising edge");

    property p_tw_cs_fall;
        @(posedge i_mclk) disable iff (i_rst)
        $fell(o_chip_select_n) && r.tw |-> o_sck;
    endproperty
    a_tw_cs_fall: assert property (p_tw_cs_fall) else $error("sck low at frame start");

    property p_tw_cs_rise;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_chip_select_n) && r.tw |-> o_sck;
    endproperty
    a_tw_cs_rise: assert property (p_tw_cs_rise) else $error("sck low at frame end");

    property p_mode_idle;
        @(posedge i_mclk) disable iff (i_rst)
        $fell(o_chip_select_n) |-> (o_sck == r.cpol) ##1 (o_sck == r.cpol)[*3];
    endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("sck not at idle level");

    property p_dir_first;
        @(posedge i_mclk) disable iff (i_rst)
        $fell(o_chip_select_n) |-> o_serial_in_pin_out == r.rd && o_serial_in_pin_oe;
    endproperty
    a_dir_first: assert property (p_dir_first) else $error("direction bit not first");

    property p_frame_len;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_chip_select_n) |-> $past(r.bitcnt) == $past(r.total) &&
            ($past(r.total) >= 7'h10) && ($past(r.total[2:0]) == 3'b000);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");

    property p_gap;
        @(posedge i_mclk) disable iff (i_rst)
        $fell(o_chip_select_n) |-> $past(r.gap) == spi_host_pkg::IDLE_CNT;
    endproperty
    a_gap: assert property (p_gap) else $error("idle gap too short");

    property p_tw_release;
        @(posedge i_mclk) disable iff (i_rst)
        (r.tw && r.rd && !o_chip_select_n && (r.bitcnt > 7'h08)) |-> !o_serial_in_pin_oe;
    endproperty
    a_tw_release: assert property (p_tw_release) else $error("shared pin driven on read");

    property p_ack;
        @(posedge i_mclk) disable iff (i_rst)
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");

endmodule

`default_nettype wire

//--- bench/spi_device_model.sv
/*
 * behavioural model of the accelerometer's primary serial target.
 * assumes the host makes select and clock; the bench resolves released data lines.
 */
`timescale 1ns/1ps
`default_nettype none

module spi_device_model #(
    parameter bit NV_SPI_EN = 1'b0,
    // address of interface_config_reg, arbitrary
    parameter logic [6:0] IFCONF_ADDR = 7'h6b,
    parameter logic [7:0] DUMMY_TX = 8'h5a
) (
    input wire logic i_rst,
    input wire logic i_chip_select_n,
    input wire logic i_sck,
    input wire logic i_sdx,
    output logic o_sdx_out,
    output logic o_sdx_oe,
    output logic o_sdo_out,
    output logic o_sdo_oe,
    output logic [7:0] o_err_cnt
);
    logic [7:0] mem [0:127];
    logic spi_sel, three_wire, tw_frame, mode11, rw, drv, bit_out;
    logic [6:0] addr;
    logic [7:0] sh, cur;
    int bits, last_bits;
    realtime t_rise;

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'h80;
        end
        spi_sel = NV_SPI_EN;
        three_wire = 1'b0;
        tw_frame = 1'b0;
        drv = 1'b0;
        bit_out = 1'b0;
        bits = 0;
        t_rise = -1.0e6;
        o_err_cnt = 8'h00;
    end

    always @(posedge i_rst) begin
        spi_sel = NV_SPI_EN;
        three_wire = 1'b0;
    end

    // --------------------------------------------------------
    // frame edges, host timing watch
    // --------------------------------------------------------
    always @(negedge i_chip_select_n) begin
        bits = 0;
        drv = 1'b0;
        tw_frame = three_wire;
        mode11 = i_sck;
        if (tw_frame && !i_sck) o_err_cnt++;
        if ($realtime - t_rise < 2000.0) o_err_cnt++;
    end

    always @(posedge i_chip_select_n) if (!i_rst) begin
        spi_sel = 1'b1;
        last_bits = bits;
        drv = 1'b0;
        t_rise = $realtime;
        if (tw_frame && !i_sck) o_err_cnt++;
    end

    // --------------------------------------------------------
    // shift in on rise, shift out on fall
    // --------------------------------------------------------
    always @(posedge i_sck) if (!i_chip_select_n) begin
        sh = {sh[6:0], i_sdx};
        bits++;
        if (bits == 1) rw = sh[0];
        if (bits == 8) addr = sh[6:0];
        // before the switch to spi the clocks are counted but no data is taken
        if (spi_sel && !rw && bits > 8 && bits % 8 == 0) begin
            mem[addr] = sh;
            if (addr == IFCONF_ADDR) three_wire = sh[0];
            addr++;
        end
    end

    always @(negedge i_sck) if (!i_chip_select_n && spi_sel && rw && bits >= 8) begin
        cur = (bits < 16) ? DUMMY_TX : mem[addr + 7'(bits / 8 - 2)];
        bit_out = cur[7 - bits % 8];
        drv = 1'b1;
    end

    // output pin only drives reads in 4-wire; shared pin only in 3-wire
    assign o_sdo_oe = drv && !tw_frame && !i_chip_select_n;
    assign o_sdo_out = bit_out;
    assign o_sdx_oe = drv && tw_frame && !i_chip_select_n;
    assign o_sdx_out = bit_out;
endmodule

`default_nettype wire

//--- bench/testbench.sv
/*
 * self-checking bench: avalon master tasks drive the host controller,
 * a device model answers on the serial link.
 * assumes spi_host_pkg and the model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic i_mclk, i_rst, i_read, i_write, o_waitrequest, cs_n, sck, h_out, h_oe;
    logic d_sdx, d_sdx_oe, d_sdo, d_sdo_oe;
    logic pat = 1'b0;
    logic [5:0] i_address;
    logic [31:0] i_writedata, o_readdata, rd;
    logic [3:0] i_byteenable;
    logic [7:0] err_cnt;
    wire logic sdx_line, sdo_line;
    int n_fail = 0;
    int n_compared = 0;
    localparam logic [31:0] RD = 32'h1 << spi_host_pkg::CTRL_READ;
    localparam logic [31:0] M11 = 32'h1 << spi_host_pkg::CTRL_MODE11;
    localparam logic [31:0] TW = 32'h1 << spi_host_pkg::CTRL_3WIRE;

    // released lines toggle every cycle so no stale value is read
    assign sdx_line = h_oe ? h_out : (d_sdx_oe ? d_sdx : pat);
    assign sdo_line = d_sdo_oe ? d_sdo : pat;

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) pat <= ~pat;

    spi_host uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_chip_select_n(cs_n),
        .o_sck(sck), .o_serial_in_pin_out(h_out), .o_serial_in_pin_oe(h_oe),
        .i_serial_in_pin(sdx_line), .i_serial_out_pin(sdo_line));

    spi_device_model dev (.i_rst(i_rst), .i_chip_select_n(cs_n), .i_sck(sck),
        .i_sdx(sdx_line), .o_sdx_out(d_sdx), .o_sdx_oe(d_sdx_oe), .o_sdo_out(d_sdo),
        .o_sdo_oe(d_sdo_oe), .o_err_cnt(err_cnt));

    // --------------------------------------------------------
    // bus and compare tasks
    // --------------------------------------------------------
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge i_mclk);
        i_write <= wr;
        i_read <= !wr;
        i_address <= a;
        i_writedata <= d;
        do begin
            @(posedge i_mclk);
            t++;
        end while (o_waitrequest !== 1'b0 && t < 50);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (t >= 50) n_fail++;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [6:0] a, input logic [3:0] n, input logic [31:0] ctrl);
        int t;
        t = 0;
        bus(1'b1, spi_host_pkg::OFS_ADDR, {25'h0, a});
        bus(1'b1, spi_host_pkg::OFS_COUNT, {28'h0, n});
        bus(1'b1, spi_host_pkg::OFS_CTRL, ctrl | 32'h1);
        do begin
            bus(1'b0, spi_host_pkg::OFS_STATUS, 32'h0);
            t++;
        end while (rd[spi_host_pkg::STAT_DONE] !== 1'b1 && t < 500);
        bus(1'b1, spi_host_pkg::OFS_STATUS, 32'h2);
        if (t >= 500) n_fail++;
    endtask

    task automatic put(input int i, input logic [7:0] v);
        bus(1'b1, 6'(spi_host_pkg::OFS_DATA + 6'(4 * i)), {24'h0, v});
    endtask

    task automatic get(input int i, input logic [7:0] exp);
        bus(1'b0, 6'(spi_host_pkg::OFS_DATA + 6'(4 * i)), 32'h0);
        check(rd, {24'h0, exp});
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset_state();
        bus(1'b0, spi_host_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 6'h3c, 32'h0);
        check(rd, 32'h0);
        check(32'(dev.spi_sel), 32'h0);
    endtask

    task automatic t_wake();
        frame(7'h00, 4'h1, 32'h1 << spi_host_pkg::CTRL_WAKE);
        check(32'(dev.spi_sel), 32'h1);
        check(32'(dev.last_bits), 32'd24);
        bus(1'b0, spi_host_pkg::OFS_STATUS, 32'h0);
        check(32'(rd[spi_host_pkg::STAT_SEL]), 32'h1);
    endtask

    task automatic t_burst_write();
        put(0, 8'ha5);
        put(1, 8'h3c);
        put(2, 8'h81);
        frame(7'h10, 4'h3, 32'h0);
        check(32'(dev.mem[7'h10]), 32'ha5);
        check(32'(dev.mem[7'h11]), 32'h3c);
        check(32'(dev.mem[7'h12]), 32'h81);
        check(32'(dev.mem[7'h13]), 32'h93);
        check(32'(dev.last_bits), 32'd32);
        check(32'(dev.mode11), 32'h0);
    endtask

    task automatic t_burst_read();
        frame(7'h10, 4'h3, RD | M11);
        check(32'(dev.mode11), 32'h1);
        check(32'(dev.last_bits), 32'd40);
        get(0, 8'ha5);
        get(1, 8'h3c);
        get(2, 8'h81);
    endtask

    task automatic t_single();
        frame(7'h40, 4'h1, RD);
        get(0, 8'hc0);
        put(0, 8'h55);
        frame(7'h41, 4'h1, M11);
        check(32'(dev.last_bits), 32'd16);
        check(32'(dev.mem[7'h41]), 32'h55);
    endtask

    task automatic t_three_wire();
        put(0, 8'h01);
        frame(7'h6b, 4'h1, 32'h0);
        check(32'(dev.three_wire), 32'h1);
        put(0, 8'h77);
        frame(7'h20, 4'h1, TW);
        check(32'(dev.mem[7'h20]), 32'h77);
        put(0, 8'h00);
        frame(7'h20, 4'h1, TW | RD);
        get(0, 8'h77);
        check(32'(err_cnt), 32'h0);
    endtask

    task automatic finish_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_fail++;
        finish_test();
    end

    initial begin
        i_rst = 1'b1;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 6'h00;
        i_writedata = 32'h0;
        i_byteenable = 4'h1;
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset_state();
        t_wake();
        t_burst_write();
        t_burst_read();
        t_single();
        t_three_wire();
        finish_test();
    end
endmodule

`default_nettype wire
